// >>> verilog/ltjc_pkg.sv
// constants, field layout and register map of the line termination and jitter configuration bank
// Function
// - rx termination bit 7 resets to high impedance
// - tx termination bit 6 resets to high impedance
// - impedance field resets 10; 10=75, 11=120
// - jitter path resets 00; 01 tx, 1x rx
// - attenuator disabled after reset until path written
// - bandwidth applied globally to rx and tx attenuators
// - fifo depth bit 0: 0 32, 1 64 bits
// - fifo depth applied globally to both attenuators
// - cable length code bits 4:0, resets zero
package ltjc_pkg;
  localparam int unsigned NUM_CHANNELS    = 8;
  localparam int unsigned CHAN_STRIDE     = 16;
  localparam logic [7:0]  CABLE_REG_INDEX = 8'h00;
  localparam logic [7:0]  TERM_REG_INDEX  = 8'h01;
  // printed offsets are not multiples of four, so byte address is index times four
  localparam int unsigned ADDR_SHIFT      = 2;
  localparam int unsigned RX_TERM_BIT     = 7;
  localparam int unsigned TX_TERM_BIT     = 6;
  localparam int unsigned IMP_MSB         = 5;
  localparam int unsigned IMP_LSB         = 4;
  localparam int unsigned JPATH_MSB       = 3;
  localparam int unsigned JPATH_LSB       = 2;
  localparam int unsigned JBW_BIT         = 1;
  localparam int unsigned FIFO_BIT        = 0;
  localparam int unsigned CABLE_MSB       = 4;
  localparam logic [7:0]  TERM_RESET      = 8'h20;
  localparam logic [4:0]  CABLE_RESET     = 5'h00;
  localparam logic [1:0]  IMP_75          = 2'h2;
  localparam logic [1:0]  IMP_120         = 2'h3;
  localparam logic [1:0]  JPATH_OFF       = 2'h0;
  localparam logic [1:0]  JPATH_TX        = 2'h1;
  localparam logic [4:0]  CABLE_SH_COAX   = 5'h1C;
  localparam logic [4:0]  CABLE_SH_TP     = 5'h1D;
  localparam logic [5:0]  FIFO_DELAY_32   = 6'h10;
  localparam logic [5:0]  FIFO_DELAY_64   = 6'h20;
endpackage

// >>> verilog/ltjc_bank.sv
// apb register bank for per-channel termination, impedance, jitter attenuator and cable codes
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
module ltjc_bank (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic      [7:0]  rx_termination_select,
  output logic      [7:0]  tx_termination_select,
  output logic      [15:0] line_impedance_select,
  output logic      [7:0]  rx_impedance_valid,
  output logic      [7:0]  jitter_enable_rx,
  output logic      [7:0]  jitter_enable_tx,
  output logic      [39:0] cable_length_code,
  output logic      [7:0]  cable_short_haul_coax,
  output logic      [7:0]  cable_short_haul_tp,
  output logic             jitter_bandwidth_select,
  output logic             fifo_depth_select,
  output logic      [5:0]  fifo_nominal_delay
);
  logic [7:0] term_reg  [ltjc_pkg::NUM_CHANNELS];
  logic [4:0] cable_reg [ltjc_pkg::NUM_CHANNELS];
  logic [7:0] next_term_reg  [ltjc_pkg::NUM_CHANNELS];
  logic [4:0] next_cable_reg [ltjc_pkg::NUM_CHANNELS];
  logic [31:0] next_prdata;
  logic        next_pslverr;
  logic [2:0]  hit_chan;
  logic        hit_term;
  logic        hit_cable;

  // decode word index into channel and register; channel at 0x00 plus 16 per channel
  function automatic logic [2:0] chan_of(input logic [9:0] idx);
    chan_of = idx[6:4];
  endfunction

  always_comb begin
    logic [9:0] idx;
    idx       = paddr[11:ltjc_pkg::ADDR_SHIFT];
    hit_chan  = chan_of(idx);
    hit_term  = (idx[9:7] == 3'h0) && ({4'h0, idx[3:0]} == ltjc_pkg::TERM_REG_INDEX);
    hit_cable = (idx[9:7] == 3'h0) && ({4'h0, idx[3:0]} == ltjc_pkg::CABLE_REG_INDEX);
  end

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;

  // register write and read data path
  always_comb begin
    next_term_reg  = term_reg;
    next_cable_reg = cable_reg;
    next_prdata    = prdata;
    next_pslverr   = 1'b0;
    if (psel && !penable) begin
      next_prdata = 32'h0000_0000;
    end
    if (psel && penable) begin
      next_pslverr = !(hit_term || hit_cable); // unmapped reads zero; this flag is unused and pslverr stays low
      if (pwrite && pstrb[0]) begin
        if (hit_term) begin
          next_term_reg[hit_chan] = pwdata[7:0];
        end
        if (hit_cable) begin
          next_cable_reg[hit_chan] = pwdata[ltjc_pkg::CABLE_MSB:0];
        end
      end
      if (!pwrite) begin
        if (hit_term) begin
          next_prdata = {24'h00_0000, term_reg[hit_chan]};
        end else if (hit_cable) begin
          next_prdata = {27'h000_0000, cable_reg[hit_chan]};
        end else begin
          next_prdata = 32'h0000_0000;
        end
      end
    end
  end

  // prdata registered at the access edge is only valid the cycle after; zero-wait master
  // sampling at that edge sees the previous value, so read data is driven combinationally
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ltjc_pkg::NUM_CHANNELS; i++) begin
        term_reg[i]  <= ltjc_pkg::TERM_RESET;
        cable_reg[i] <= ltjc_pkg::CABLE_RESET;
      end
      pslverr <= 1'b0;
    end else begin
      term_reg  <= next_term_reg;
      cable_reg <= next_cable_reg;
      pslverr   <= 1'b0;
    end
  end

  logic unused_regs;
  assign unused_regs = next_pslverr ^ (|next_prdata);

  // read data answered in the access cycle itself; pslverr is held low
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && penable && !pwrite) begin
      if (hit_term) begin
        prdata = {24'h00_0000, term_reg[hit_chan]};
      end else if (hit_cable) begin
        prdata = {27'h000_0000, cable_reg[hit_chan]};
      end
    end
  end

  // per-channel control decode
  always_comb begin
    for (int c = 0; c < ltjc_pkg::NUM_CHANNELS; c++) begin
      rx_termination_select[c] = term_reg[c][ltjc_pkg::RX_TERM_BIT];
      tx_termination_select[c] = term_reg[c][ltjc_pkg::TX_TERM_BIT];
      line_impedance_select[2*c +: 2] =
        term_reg[c][ltjc_pkg::IMP_MSB:ltjc_pkg::IMP_LSB];
      rx_impedance_valid[c] = term_reg[c][ltjc_pkg::IMP_MSB];
      jitter_enable_tx[c] =
        term_reg[c][ltjc_pkg::JPATH_MSB:ltjc_pkg::JPATH_LSB] == ltjc_pkg::JPATH_TX;
      jitter_enable_rx[c] = term_reg[c][ltjc_pkg::JPATH_MSB];
      cable_length_code[5*c +: 5] = cable_reg[c];
      cable_short_haul_coax[c] = cable_reg[c] == ltjc_pkg::CABLE_SH_COAX;
      cable_short_haul_tp[c]   = cable_reg[c] == ltjc_pkg::CABLE_SH_TP;
    end
  end

  // global settings: channel 0 copy drives both attenuators of all channels
  assign jitter_bandwidth_select = term_reg[0][ltjc_pkg::JBW_BIT];
  assign fifo_depth_select       = term_reg[0][ltjc_pkg::FIFO_BIT];
  assign fifo_nominal_delay = fifo_depth_select ? ltjc_pkg::FIFO_DELAY_64
                                                : ltjc_pkg::FIFO_DELAY_32;
endmodule // ltjc_bank

// >>> tb/ltjc_host.sv
// apb host model for the configuration bank
`timescale 1ns/1ns
module ltjc_host (
  input  wire logic        pclk, pready,
  input  wire logic [31:0] prdata,
  output logic             psel = '0, penable = '0, pwrite = '0,
  output logic      [11:0] paddr = '0,
  output logic      [31:0] pwdata = '0
);
  // request held until pready or for at most 40 cycles; released data is scrambled so stale values cannot pass
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output bit ok);
    int i;
    i = 0;
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk) i++; while (pready !== 1'b1 && i < 40);
    r = prdata;
    ok = pready === 1'b1;
    {psel, penable, pwdata} <= {2'h0, ~d};
    @(posedge pclk);
  endtask
endmodule // ltjc_host

// >>> tb/ltjc_bank_checker.sv
// port assertions for the configuration bank
`timescale 1ns/1ns
module ltjc_bank_checker (
  input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [7:0]  rx_termination_select, tx_termination_select,
  input wire logic [7:0]  jitter_enable_rx, jitter_enable_tx,
  input wire logic        jitter_bandwidth_select, fifo_depth_select,
  input wire logic [5:0]  fifo_nominal_delay
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // write that lands in the channel 0 termination word
  wire w0 = psel && penable && pwrite && pstrb[0] && paddr == 12'h004;
  AST_READY: assert property (psel && penable |-> pready && !pslverr) else $error("ready");
  AST_RX: assert property (w0 |=> rx_termination_select[0] == $past(pwdata[7])) else $error("rx");
  AST_TX: assert property (w0 |=> tx_termination_select[0] == $past(pwdata[6])) else $error("tx");
  AST_BW: assert property (w0 |=> jitter_bandwidth_select == $past(pwdata[1])) else $error("bw");
  AST_FIFO: assert property (w0 |=> fifo_depth_select == $past(pwdata[0])) else $error("fifo");
  AST_DELAY: assert property (fifo_nominal_delay == (fifo_depth_select ? 6'h20 : 6'h10))
    else $error("delay");
  AST_PATH: assert property (!(|(jitter_enable_rx & jitter_enable_tx))) else $error("path");
  AST_OFF: assert property ($rose(presetn) |-> !(|{jitter_enable_rx, jitter_enable_tx}))
    else $error("off");
  cover property (w0 && pwdata[3:2] == 2'h1);
  cover property (w0 && pwdata[0]);
  cover property (psel && penable && !pwrite);
endmodule // ltjc_bank_checker
bind ltjc_bank ltjc_bank_checker chk (.*);

// >>> tb/line_termination_jitter_config_test.sv
// self-checking bench for the configuration bank
`timescale 1ns/1ns
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", n, e, s); end end
module line_termination_jitter_config_test;
  logic        pclk = 0, presetn = 0, psel, penable, pwrite, pready, pslverr, ok;
  logic [3:0]  pstrb = 4'hF;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0]  rx_termination_select, tx_termination_select, rx_impedance_valid, x;
  logic [7:0]  jitter_enable_rx, jitter_enable_tx, cable_short_haul_coax, cable_short_haul_tp;
  logic [15:0] line_impedance_select;
  logic [39:0] cable_length_code;
  logic        jitter_bandwidth_select, fifo_depth_select;
  logic [5:0]  fifo_nominal_delay;
  logic [7:0]  m [16];
  int          n_fail = 0, cmp_count = 0;
  ltjc_bank DUT (.*);
  ltjc_host HOST (.*);
  always #2 pclk = ~pclk;
  task complete_run;
    if (n_fail == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // model words: even index cable code, odd index termination word
  task do_reset;
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (m[i]) m[i] = i[0] ? 8'h20 : 8'h00;
    @(posedge pclk);
  endtask
  task chk_all;
    for (int c = 0; c < 8; c++) begin
      x = {rx_termination_select[c], tx_termination_select[c], line_impedance_select[c*2+:2],
           jitter_enable_rx[c], jitter_enable_tx[c], rx_impedance_valid[c], 1'b0};
      `CHK("term", {m[c*2+1][7:3], m[c*2+1][3:2] == 2'h1, m[c*2+1][5], 1'b0}, x)
      x = {cable_length_code[c*5+:5], cable_short_haul_coax[c], cable_short_haul_tp[c], 1'b0};
      `CHK("cable", {m[c*2][4:0], m[c*2][4:0] == 5'h1C, m[c*2][4:0] == 5'h1D, 1'b0}, x)
    end
    x = {jitter_bandwidth_select, fifo_depth_select, fifo_nominal_delay};
    `CHK("global", {m[1][1:0], (m[1][0] ? 6'h20 : 6'h10)}, x)
  endtask
  // one access; unmapped places read zero and drop writes
  task acc(input logic w, input logic [11:0] a, input logic [7:0] d);
    logic hit;
    logic [3:0] i;
    hit = a[11:9] == 3'h0 && a[5:3] == 3'h0;
    i = {a[8:6], a[2]};
    HOST.xfer(w, a, {24'($urandom), d}, r, ok);
    if (!ok) begin n_fail++; complete_run(); end
    if (w && hit && pstrb[0]) m[i] = i[0] ? d : {3'h0, d[4:0]};
    if (!w) `CHK("read", (hit ? {24'h0, m[i]} : 32'h0), r)
    chk_all();
  endtask
  initial begin
    int k;
    r = $urandom(32'hED5B432E);
    do_reset();
    for (k = 0; k < 32; k++) acc(1'b0, 12'({k[4:2], 2'h0, k[1:0], 2'h0}), 8'h00);
    repeat (300) begin
      k = $urandom;
      // lane 0 strobe low now and then: such writes must be dropped
      pstrb <= {3'h7, |k[14:13]};
      acc(k[31], 12'({k[4:2], 2'h0, k[1:0], 2'h0}), k[12:5]);
    end
    pstrb <= 4'hF;
    acc(1'b1, 12'h0C0, 8'h1C);
    acc(1'b1, 12'h0C0, 8'h1D);
    do_reset();
    chk_all();
    complete_run();
  end
endmodule // line_termination_jitter_config_test
